// File: hw/smalu_consts.svh
// constants for the small mcu alu operation block
`ifndef SMALU_CONSTS_SVH
`define SMALU_CONSTS_SVH
`define SMALU_DATA_W 8
`define SMALU_ADDR_W 5
`define SMALU_ADDR_MAX 5'h1f
`define SMALU_PORT_LO 3'h6
`define SMALU_PORT_HI 3'h7
`define SMALU_RST_BYTE 8'h00
`define SMALU_RST_DIR 8'hff
`endif

// File: hw/smalu_pkg.sv
// types for the small mcu alu operation block
package smalu_pkg;
    typedef enum logic [2:0] {
        SMALU_OP_NONE = 3'b000,
        SMALU_OP_ROTATE_RIGHT_CARRY = 3'b001,
        SMALU_OP_NIBBLE_SWAP = 3'b010,
        SMALU_OP_DIRECTION_LOAD = 3'b011,
        SMALU_OP_LITERAL_XOR = 3'b100,
        SMALU_OP_REGISTER_XOR = 3'b101
    } smalu_op_t;

    typedef struct packed {
        logic valid;
        smalu_op_t op;
        logic [4:0] faddr;
        logic dest_file;
        logic [7:0] literal;
        logic [7:0] fdata;
    } smalu_req_t;

    typedef struct packed {
        logic fwe;
        logic [4:0] faddr;
        logic [7:0] fdata;
    } smalu_fwr_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [7:0] acc;
        logic carry;
        logic zero;
        logic [7:0] dir6;
        logic [7:0] dir7;
        smalu_fwr_t fwr;
        logic done;
    } smalu_state_t;
endpackage

// File: hw/smalu_core.sv
// execution datapath for five operations of a small 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "smalu_consts.svh"

// Function
// - rotate-right shifts toward bit 0 through carry, other flags kept.
// - for rotate, swap and register-xor, destination 0 writes the accumulator, 1 the file register 0..31.
// - nibble-swap exchanges bits 3:0 and 7:4 and leaves every flag alone.
// - direction-load copies the accumulator to port 6 or 7, no flag moves.
// - register-xor writes acc xor file byte to the destination, zero only.
// - literal-xor xors an 8-bit immediate 0..255 with the accumulator.
module smalu_core #(
    parameter int HAS_PORT7 = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // operation request, file byte already read by the caller
    input wire smalu_pkg::smalu_req_t req_i,
    // file register write back
    output logic fwe_o,
    output logic [4:0] faddr_o,
    output logic [7:0] fdata_o,
    // architectural state
    output logic [7:0] acc_o,
    output logic carry_o,
    output logic zero_o,
    output logic [7:0] dir6_o,
    output logic [7:0] dir7_o,
    output logic done_o
);
    import smalu_pkg::*;

    // the port 7 register exists or not, nothing in between
    if (HAS_PORT7 != 0 && HAS_PORT7 != 1)
    begin : g_bad_port7
        $error("HAS_PORT7 must be 0 or 1");
    end

    smalu_state_t s_q;
    smalu_state_t s_d;
    logic [1:0] sync_q;
    logic rst_n;
    logic [7:0] res;
    logic is_file_op;

    // two-stage release keeps reset removal clean against the clock
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_q <= 2'b00;
        end
        else
        begin
            sync_q <= {sync_q[0], 1'b1};
        end
    end
    assign rst_n = sync_q[1];

    always_comb
    begin
        s_d = s_q;
        // only the second synchroniser stage may be read
        s_d.rst_sync = {rst_n, rst_n};
        s_d.fwr.fwe = 1'b0;
        s_d.done = 1'b0;
        res = `SMALU_RST_BYTE;
        is_file_op = 1'b0;
        if (req_i.valid)
        begin
            s_d.done = 1'b1;
            unique case (req_i.op)
                SMALU_OP_ROTATE_RIGHT_CARRY:
                begin
                    res = {s_q.carry, req_i.fdata[7:1]};
                    s_d.carry = req_i.fdata[0];
                    is_file_op = 1'b1;
                end
                SMALU_OP_NIBBLE_SWAP:
                begin
                    res = {req_i.fdata[3:0], req_i.fdata[7:4]};
                    is_file_op = 1'b1;
                end
                SMALU_OP_DIRECTION_LOAD:
                begin
                    // other operand values are ignored, no flag moves
                    if (req_i.faddr[2:0] == `SMALU_PORT_LO)
                    begin
                        s_d.dir6 = s_q.acc;
                    end
                    else if (req_i.faddr[2:0] == `SMALU_PORT_HI
                        && HAS_PORT7 == 1)
                    begin
                        s_d.dir7 = s_q.acc;
                    end
                end
                SMALU_OP_LITERAL_XOR:
                begin
                    res = s_q.acc ^ req_i.literal;
                    s_d.acc = res;
                    s_d.zero = (res == `SMALU_RST_BYTE);
                end
                SMALU_OP_REGISTER_XOR:
                begin
                    res = s_q.acc ^ req_i.fdata;
                    s_d.zero = (res == `SMALU_RST_BYTE);
                    is_file_op = 1'b1;
                end
                default:
                begin
                    s_d.done = 1'b0;
                end
            endcase
            if (is_file_op)
            begin
                if (req_i.dest_file)
                begin
                    s_d.fwr.fwe = 1'b1;
                    s_d.fwr.faddr = req_i.faddr;
                    s_d.fwr.fdata = res;
                end
                else
                begin
                    s_d.acc = res;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.rst_sync <= 2'b00;
            s_q.acc <= `SMALU_RST_BYTE;
            s_q.carry <= 1'b0;
            s_q.zero <= 1'b0;
            s_q.dir6 <= `SMALU_RST_DIR;
            s_q.dir7 <= `SMALU_RST_DIR;
            s_q.fwr <= '0;
            s_q.done <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign fwe_o = s_q.fwr.fwe;
    assign faddr_o = s_q.fwr.faddr;
    assign fdata_o = s_q.fwr.fdata;
    assign acc_o = s_q.acc;
    assign carry_o = s_q.carry;
    assign zero_o = s_q.zero;
    assign dir6_o = s_q.dir6;
    assign dir7_o = s_q.dir7;
    assign done_o = s_q.done;

    a_rotate_carry: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_ROTATE_RIGHT_CARRY
        |=> carry_o == $past(req_i.fdata[0]) && zero_o == $past(zero_o))
        else $error("rotate carry wrong");
    a_rotate_dest: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_ROTATE_RIGHT_CARRY
            && req_i.dest_file
        |=> fwe_o && fdata_o == {$past(carry_o), $past(req_i.fdata[7:1])}
            && acc_o == $past(acc_o))
        else $error("rotate result wrong");
    a_swap_acc: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_NIBBLE_SWAP && !req_i.dest_file
        |=> acc_o == {$past(req_i.fdata[3:0]), $past(req_i.fdata[7:4])}
            && $stable(carry_o) && $stable(zero_o) && !fwe_o)
        else $error("swap wrong");
    a_swap_file: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_NIBBLE_SWAP && req_i.dest_file
        |=> fwe_o
            && fdata_o == {$past(req_i.fdata[3:0]), $past(req_i.fdata[7:4])}
            && $stable(acc_o) && $stable(carry_o) && $stable(zero_o))
        else $error("swap to file wrong");
    a_dir_load: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_DIRECTION_LOAD
            && req_i.faddr[2:0] == 3'h6
        |=> dir6_o == $past(acc_o) && $stable(carry_o) && $stable(zero_o))
        else $error("direction load wrong");
    a_dir_port7: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_DIRECTION_LOAD
            && req_i.faddr[2:0] == 3'h7 && HAS_PORT7 == 1
        |=> dir7_o == $past(acc_o) && $stable(dir6_o) && !fwe_o
            && $stable(carry_o) && $stable(zero_o))
        else $error("port 7 direction load wrong");
    a_regxor_zero: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_REGISTER_XOR
        |=> zero_o == ($past(acc_o) == $past(req_i.fdata))
            && $stable(carry_o))
        else $error("register xor zero wrong");
    a_regxor_file: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_REGISTER_XOR && req_i.dest_file
        |=> fwe_o && fdata_o == ($past(acc_o) ^ $past(req_i.fdata))
            && faddr_o == $past(req_i.faddr) && $stable(acc_o))
        else $error("register xor to file wrong");
    a_litxor_acc: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_LITERAL_XOR
        |=> acc_o == ($past(acc_o) ^ $past(req_i.literal)) && !fwe_o)
        else $error("literal xor wrong");
    a_litxor_zero: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_LITERAL_XOR
            && req_i.literal == acc_o
        |=> zero_o ##1 (zero_o || done_o))
        else $error("literal xor zero wrong");
    a_litxor_nonzero: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        req_i.valid && req_i.op == SMALU_OP_LITERAL_XOR
            && req_i.literal != acc_o
        |=> !zero_o && $stable(carry_o))
        else $error("literal xor nonzero wrong");
    a_file_dest: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        fwe_o |-> $past(req_i.valid) && $past(req_i.dest_file)
            && faddr_o == $past(req_i.faddr))
        else $error("file write without destination");
endmodule
`default_nettype wire

// File: tb/small_mcu_alu_ops_test.sv
// self-checking bench for the small mcu alu operation block
`timescale 1ns/1ps
`default_nettype none
module small_mcu_alu_ops_test;
    import smalu_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    smalu_req_t req_i = '0;
    logic fwe_o, carry_o, zero_o, done_o;
    logic [4:0] faddr_o;
    logic [7:0] fdata_o, acc_o, dir6_o, dir7_o;
    int errors = 0;
    int comparisons = 0;

    smalu_core i_smalu_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .req_i(req_i), .fwe_o(fwe_o), .faddr_o(faddr_o),
        .fdata_o(fdata_o), .acc_o(acc_o), .carry_o(carry_o),
        .zero_o(zero_o), .dir6_o(dir6_o), .dir7_o(dir7_o),
        .done_o(done_o));

    always #20 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one idle edge, then one request for exactly one taking edge;
    // the idle edge keeps valid from being lowered and raised at once
    task automatic run_op(input smalu_op_t op, input logic [4:0] fa,
        input logic dst, input logic [7:0] lit, input logic [7:0] fd);
        @(posedge ref_clk_i);
        #1;
        req_i = '{valid: 1'b1, op: op, faddr: fa, dest_file: dst,
            literal: lit, fdata: fd};
        @(posedge ref_clk_i);
        #1;
        req_i.valid = 1'b0;
        chk({7'h00, done_o}, 8'h01);
    endtask

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic test_literal_xor();
        run_op(SMALU_OP_LITERAL_XOR, 5'h00, 1'b1, 8'hff, 8'h00);
        chk(acc_o, 8'hff);
        chk({7'h00, zero_o}, 8'h00);
        chk({7'h00, fwe_o}, 8'h00);
        run_op(SMALU_OP_LITERAL_XOR, 5'h00, 1'b0, 8'hff, 8'h00);
        chk(acc_o, 8'h00);
        chk({7'h00, zero_o}, 8'h01);
        $display("test literal xor done");
    endtask

    task automatic test_rotate();
        run_op(SMALU_OP_ROTATE_RIGHT_CARRY, 5'h1f, 1'b1, 8'h00, 8'h81);
        chk({7'h00, fwe_o}, 8'h01);
        chk({3'h0, faddr_o}, 8'h1f);
        chk(fdata_o, 8'h40);
        chk({7'h00, carry_o}, 8'h01);
        chk({7'h00, zero_o}, 8'h01);
        chk(acc_o, 8'h00);
        run_op(SMALU_OP_ROTATE_RIGHT_CARRY, 5'h00, 1'b0, 8'h00, 8'h01);
        chk(acc_o, 8'h80);
        chk({7'h00, carry_o}, 8'h01);
        chk({7'h00, fwe_o}, 8'h00);
        $display("test rotate done");
    endtask

    task automatic test_swap();
        run_op(SMALU_OP_NIBBLE_SWAP, 5'h02, 1'b0, 8'h00, 8'ha5);
        chk(acc_o, 8'h5a);
        chk({6'h00, carry_o, zero_o}, 8'h03);
        run_op(SMALU_OP_NIBBLE_SWAP, 5'h00, 1'b1, 8'h00, 8'h3c);
        chk({7'h00, fwe_o}, 8'h01);
        chk({3'h0, faddr_o}, 8'h00);
        chk(fdata_o, 8'hc3);
        chk(acc_o, 8'h5a);
        $display("test swap done");
    endtask

    task automatic test_direction();
        run_op(SMALU_OP_DIRECTION_LOAD, 5'h06, 1'b0, 8'h00, 8'h00);
        chk(dir6_o, 8'h5a);
        chk(dir7_o, 8'hff);
        run_op(SMALU_OP_DIRECTION_LOAD, 5'h07, 1'b0, 8'h00, 8'h00);
        chk(dir7_o, 8'h5a);
        chk({6'h00, carry_o, zero_o}, 8'h03);
        $display("test direction done");
    endtask

    task automatic test_register_xor();
        run_op(SMALU_OP_REGISTER_XOR, 5'h04, 1'b0, 8'h00, 8'h5b);
        chk(acc_o, 8'h01);
        chk({6'h00, carry_o, zero_o}, 8'h02);
        run_op(SMALU_OP_REGISTER_XOR, 5'h05, 1'b1, 8'h00, 8'h01);
        chk({7'h00, fwe_o}, 8'h01);
        chk({3'h0, faddr_o}, 8'h05);
        chk(fdata_o, 8'h00);
        chk({6'h00, carry_o, zero_o}, 8'h03);
        chk(acc_o, 8'h01);
        $display("test register xor done");
    endtask

    // a strobe without a legal op must leave everything alone
    task automatic test_refused();
        @(posedge ref_clk_i);
        #1;
        req_i = '{valid: 1'b1, op: SMALU_OP_NONE, faddr: 5'h06,
            dest_file: 1'b1, literal: 8'hff, fdata: 8'hff};
        @(posedge ref_clk_i);
        #1;
        req_i.valid = 1'b0;
        chk({6'h00, done_o, fwe_o}, 8'h00);
        chk(acc_o, 8'h01);
        chk(dir6_o, 8'h5a);
        run_op(SMALU_OP_DIRECTION_LOAD, 5'h05, 1'b0, 8'h00, 8'h00);
        chk(dir6_o, 8'h5a);
        chk(dir7_o, 8'h5a);
        chk({6'h00, carry_o, zero_o}, 8'h03);
        $display("test refused done");
    endtask

    task automatic test_reset_values();
        chk(acc_o, 8'h00);
        chk({6'h00, carry_o, zero_o}, 8'h00);
        chk(dir6_o, 8'hff);
        chk(dir7_o, 8'hff);
        chk({6'h00, done_o, fwe_o}, 8'h00);
        $display("test reset done");
    endtask

    // reset in mid-run must bring back the power-up state
    task automatic test_reset_mid();
        @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        test_reset_values();
    endtask

    // the whole run is some fifty cycles; this bound is generous
    initial
    begin
        #20000;
        errors++;
        final_report();
    end

    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        test_reset_values();
        test_literal_xor();
        test_rotate();
        test_swap();
        test_direction();
        test_register_xor();
        test_refused();
        test_reset_mid();
        final_report();
    end
endmodule
`default_nettype wire
